// >>> hdl/alarm_threshold_regs.sv
// input alarm threshold register bank behind an apb slave
// assumes an apb4 master on pclk and conversion results synchronous to pclk
`timescale 1ns/100ps

module alarm_threshold_regs #(
  parameter int RESULT_WIDTH = 16
) (
  // clock and reset
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  // apb slave
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [7:0]                paddr,
  input  wire logic [31:0]               pwdata,
  input  wire logic [3:0]                pstrb,
  output logic      [31:0]               prdata,
  output logic                           pready,
  output logic                           pslverr,
  // conversion results
  input  wire logic [RESULT_WIDTH-1:0]   result,
  input  wire logic                      result_valid,
  // alarms
  output logic                           alarm_high,
  output logic                           alarm_low,
  output logic                           irq
);

  typedef struct packed {
    logic [15:0] upper_limit;
    logic [15:0] lower_limit;
    logic [7:0]  hyst_field;
    logic        live_high;
    logic        live_low;
    logic        trip_high;
    logic        trip_low;
    logic        read_status;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } regs_state_t;

  regs_state_t st;
  regs_state_t next_st;

  alarm_if link ();

  logic                           setup;
  logic                           done;
  logic                           wr_done;
  logic                           rd_done;
  logic [alarm_pkg::INT_COUNT-1:0] int_status;
  logic [alarm_pkg::INT_COUNT-1:0] int_mask;
  logic [alarm_pkg::INT_COUNT-1:0] int_events;
  logic [alarm_pkg::INT_COUNT-1:0] int_clear;
  logic                           int_mask_we;
  logic                           irq_level;
  logic [31:0]                    read_word;

  generate
    if (RESULT_WIDTH < 8 || RESULT_WIDTH > alarm_pkg::LIMIT_WIDTH) begin : g_bad_width
      $error("alarm_threshold_regs: RESULT_WIDTH must lie in 8..16");
    end

    // the bus port, the limits and the link carry fixed widths
    if (alarm_pkg::ADDR_WIDTH != 8) begin : g_bad_addr_width
      $error("alarm_threshold_regs: ADDR_WIDTH must match the 8-bit paddr");
    end
    if (alarm_pkg::LIMIT_WIDTH != 16) begin : g_bad_limit_width
      $error("alarm_threshold_regs: LIMIT_WIDTH must match the 16-bit limits");
    end
    if (alarm_pkg::HYST_FIELD_W != 8) begin : g_bad_field_width
      $error("alarm_threshold_regs: HYST_FIELD_W must be one byte lane");
    end
    if (alarm_pkg::HYST_WIDTH != 6) begin : g_bad_hyst_width
      $error("alarm_threshold_regs: HYST_WIDTH must match the 6-bit link");
    end
    if (alarm_pkg::HYST_VALUE_LSB != 2) begin : g_bad_hyst_lsb
      $error("alarm_threshold_regs: hysteresis value must sit in field bits 7:2");
    end

    // field placement that the word merges and the read mux rely on
    if (alarm_pkg::HYST_FIELD_LSB != 24 || alarm_pkg::UPPER_LIMIT_LSB != 0) begin : g_bad_upper
      $error("alarm_threshold_regs: upper register fields out of place");
    end
    if (alarm_pkg::LOWER_LIMIT_LSB != 0) begin : g_bad_lower
      $error("alarm_threshold_regs: lower limit must start at bit 0");
    end
    if (alarm_pkg::STAT_LIVE_LOW > 31 || alarm_pkg::STAT_LIVE_HIGH > 31) begin : g_bad_status
      $error("alarm_threshold_regs: status bits must fit the bus word");
    end
    if (alarm_pkg::INT_COUNT != 2) begin : g_bad_int_count
      $error("alarm_threshold_regs: exactly two interrupt events are wired");
    end
    if (alarm_pkg::INT_HIGH == alarm_pkg::INT_LOW) begin : g_bad_int_bits
      $error("alarm_threshold_regs: interrupt bits must differ");
    end

    // every register must be one aligned word
    if (alarm_pkg::ADDR_UPPER % 4 != 0 || alarm_pkg::ADDR_LOWER % 4 != 0) begin : g_bad_align
      $error("alarm_threshold_regs: limit registers must be word aligned");
    end
    if (alarm_pkg::ADDR_STATUS % 4 != 0 || alarm_pkg::ADDR_INT_MASK % 4 != 0) begin : g_bad_align2
      $error("alarm_threshold_regs: status and mask must be word aligned");
    end
    if (alarm_pkg::ADDR_INT_STATUS % 4 != 0) begin : g_bad_align_int
      $error("alarm_threshold_regs: interrupt status must be word aligned");
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // address decode, shared by setup and completion
  function automatic logic addr_hit(input logic [7:0] a);
    case (a)
      alarm_pkg::ADDR_STATUS,
      alarm_pkg::ADDR_UPPER,
      alarm_pkg::ADDR_LOWER,
      alarm_pkg::ADDR_INT_STATUS,
      alarm_pkg::ADDR_INT_MASK: addr_hit = 1'b1;
      default:                  addr_hit = 1'b0;
    endcase
  endfunction

  // replace the strobed bytes of a word
  function automatic logic [31:0] merge_bytes(input logic [31:0] old_word,
                                              input logic [31:0] new_word,
                                              input logic [3:0]  strb);
    logic [31:0] m;
    m = old_word;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        m[8*b +: 8] = new_word[8*b +: 8];
      end
    end
    merge_bytes = m;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // bus phase qualifiers
  always_comb begin
    setup   = psel & ~penable;
    done    = psel & penable & st.pready;
    wr_done = done & pwrite & addr_hit(paddr);
    rd_done = done & ~pwrite & addr_hit(paddr);
  end

  ////////////////////////////////////////////////////////////////////////////
  // read mux, reserved bits stay zero
  always_comb begin
    read_word = 32'h0000_0000;
    case (paddr)
      alarm_pkg::ADDR_STATUS: begin
        read_word[alarm_pkg::STAT_LIVE_HIGH] = st.live_high;
        read_word[alarm_pkg::STAT_LIVE_LOW]  = st.live_low;
        read_word[alarm_pkg::STAT_TRIP_HIGH] = st.trip_high;
        read_word[alarm_pkg::STAT_TRIP_LOW]  = st.trip_low;
        read_word[alarm_pkg::STAT_SUMMARY]   = st.trip_high | st.trip_low;
      end
      alarm_pkg::ADDR_UPPER: begin
        read_word[alarm_pkg::UPPER_LIMIT_LSB +: 16] = st.upper_limit;
        read_word[alarm_pkg::HYST_FIELD_LSB +: 8]   = st.hyst_field;
      end
      alarm_pkg::ADDR_LOWER: begin
        read_word[alarm_pkg::LOWER_LIMIT_LSB +: 16] = st.lower_limit;
      end
      alarm_pkg::ADDR_INT_STATUS: begin
        read_word[alarm_pkg::INT_COUNT-1:0] = int_status;
      end
      alarm_pkg::ADDR_INT_MASK: begin
        read_word[alarm_pkg::INT_COUNT-1:0] = int_mask;
      end
      default: read_word = 32'h0000_0000;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // register state
  always_comb begin
    logic [31:0] upper_word;
    logic [31:0] lower_word;
    upper_word = 32'h0000_0000;
    lower_word = 32'h0000_0000;
    next_st    = st;

    // one wait-free access cycle: pready rises in the cycle after setup
    next_st.pready  = setup;
    next_st.pslverr = setup & ~addr_hit(paddr);
    next_st.prdata  = 32'h0000_0000;
    if (setup && !pwrite) begin
      next_st.prdata = read_word;
    end
    next_st.read_status = setup & ~pwrite & (paddr == alarm_pkg::ADDR_STATUS);

    // reserved lanes are written but never stored
    if (wr_done && paddr == alarm_pkg::ADDR_UPPER) begin
      upper_word = {st.hyst_field, 8'h00, st.upper_limit};
      upper_word = merge_bytes(upper_word, pwdata, pstrb);
      next_st.upper_limit = upper_word[alarm_pkg::UPPER_LIMIT_LSB +: 16];
      next_st.hyst_field  = upper_word[alarm_pkg::HYST_FIELD_LSB +: 8];
    end
    if (wr_done && paddr == alarm_pkg::ADDR_LOWER) begin
      lower_word = {16'h0000, st.lower_limit};
      lower_word = merge_bytes(lower_word, pwdata, pstrb);
      next_st.lower_limit = lower_word[alarm_pkg::LOWER_LIMIT_LSB +: 16];
    end

    // live copy of the comparator
    next_st.live_high = link.live_high;
    next_st.live_low  = link.live_low;

    // tripped flags clear only where the completed read reported them
    if (rd_done && st.read_status) begin
      if (st.prdata[alarm_pkg::STAT_TRIP_HIGH]) begin
        next_st.trip_high = 1'b0;
      end
      if (st.prdata[alarm_pkg::STAT_TRIP_LOW]) begin
        next_st.trip_low = 1'b0;
      end
    end
    if (link.rise_high) begin
      next_st.trip_high = 1'b1;
    end
    if (link.rise_low) begin
      next_st.trip_low = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st.upper_limit <= alarm_pkg::UPPER_RESET;
      st.lower_limit <= alarm_pkg::LOWER_RESET;
      st.hyst_field  <= alarm_pkg::HYST_RESET;
      st.live_high   <= 1'b0;
      st.live_low    <= 1'b0;
      st.trip_high   <= 1'b0;
      st.trip_low    <= 1'b0;
      st.read_status <= 1'b0;
      st.prdata      <= 32'h0000_0000;
      st.pready      <= 1'b0;
      st.pslverr     <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // comparator feed; only the upper six hysteresis bits count
  assign link.upper_limit  = st.upper_limit;
  assign link.lower_limit  = st.lower_limit;
  assign link.hyst         = st.hyst_field[alarm_pkg::HYST_VALUE_LSB +: 6];
  assign link.result       = 16'(result);
  assign link.result_valid = result_valid;

  alarm_compare u_compare (
    .pclk    (pclk),
    .presetn (presetn),
    .link    (link.cmp)
  );

  ////////////////////////////////////////////////////////////////////////////
  // interrupt events are the trip edges
  always_comb begin
    int_events                     = '0;
    int_events[alarm_pkg::INT_HIGH] = link.rise_high;
    int_events[alarm_pkg::INT_LOW]  = link.rise_low;
    int_clear   = '0;
    int_mask_we = wr_done & (paddr == alarm_pkg::ADDR_INT_MASK) & pstrb[0];
    if (wr_done && paddr == alarm_pkg::ADDR_INT_STATUS && pstrb[0]) begin
      int_clear = pwdata[alarm_pkg::INT_COUNT-1:0];
    end
  end

  alarm_irq #(
    .N (alarm_pkg::INT_COUNT)
  ) u_irq (
    .pclk       (pclk),
    .presetn    (presetn),
    .event_in   (int_events),
    .clear      (int_clear),
    .mask_we    (int_mask_we),
    .mask_wdata (pwdata[alarm_pkg::INT_COUNT-1:0]),
    .status     (int_status),
    .mask       (int_mask),
    .irq        (irq_level)
  );

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign prdata     = st.prdata;
  assign pready     = st.pready;
  assign pslverr    = st.pslverr;
  assign alarm_high = st.live_high;
  assign alarm_low  = st.live_low;
  assign irq        = irq_level;

endmodule

// >>> hdl/alarm_pkg.sv
// constants for the input alarm threshold register bank
// assumes a 32-bit apb slave with byte addresses and byte strobes
package alarm_pkg;

  ////////////////////////////////////////////////////////////////////////////
  localparam int          ADDR_WIDTH      = 8;
  localparam int          LIMIT_WIDTH     = 16;
  localparam int          HYST_WIDTH      = 6;
  localparam int          HYST_FIELD_W    = 8;

  // register byte addresses
  localparam logic [7:0]  ADDR_STATUS     = 8'h20;
  localparam logic [7:0]  ADDR_UPPER      = 8'h24;
  localparam logic [7:0]  ADDR_LOWER      = 8'h28;
  localparam logic [7:0]  ADDR_INT_STATUS = 8'h2c;
  localparam logic [7:0]  ADDR_INT_MASK   = 8'h30;

  // upper limit register layout
  localparam int          UPPER_LIMIT_LSB = 0;
  localparam int          HYST_FIELD_LSB  = 24;
  localparam int          HYST_VALUE_LSB  = 2;

  // lower limit register layout
  localparam int          LOWER_LIMIT_LSB = 0;

  // alarm status register layout
  localparam int          STAT_SUMMARY    = 0;
  localparam int          STAT_TRIP_HIGH  = 4;
  localparam int          STAT_TRIP_LOW   = 5;
  localparam int          STAT_LIVE_HIGH  = 10;
  localparam int          STAT_LIVE_LOW   = 11;

  // interrupt status and mask layout
  localparam int          INT_COUNT       = 2;
  localparam int          INT_HIGH        = 0;
  localparam int          INT_LOW         = 1;

  // reset values
  localparam logic [15:0] UPPER_RESET     = 16'hffff;
  localparam logic [15:0] LOWER_RESET     = 16'h0000;
  localparam logic [7:0]  HYST_RESET      = 8'h00;
  localparam logic [1:0]  MASK_RESET      = 2'h0;

  typedef enum logic [1:0] {
    ALARM_CLEAR  = 2'b01,
    ALARM_RAISED = 2'b10
  } alarm_state_t;

endpackage

// >>> hdl/alarm_if.sv
// carrier between the register bank and the threshold comparator
// assumes both ends run on the same pclk
`timescale 1ns/100ps
interface alarm_if;
  logic [15:0] upper_limit;
  logic [15:0] lower_limit;
  logic [5:0]  hyst;
  logic [15:0] result;
  logic        result_valid;
  logic        live_high;
  logic        live_low;
  logic        rise_high;
  logic        rise_low;

  modport cfg (
    output upper_limit, lower_limit, hyst, result, result_valid,
    input  live_high, live_low, rise_high, rise_low
  );

  modport cmp (
    input  upper_limit, lower_limit, hyst, result, result_valid,
    output live_high, live_low, rise_high, rise_low
  );
endinterface

// >>> hdl/alarm_compare.sv
// hysteretic comparison of conversion results against both limits
// assumes result_valid is a one-cycle strobe with result stable beside it
`timescale 1ns/100ps
module alarm_compare (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // limits in, flags out
  alarm_if.cmp     link
);

  typedef struct packed {
    alarm_pkg::alarm_state_t high_state;
    alarm_pkg::alarm_state_t low_state;
    logic                    rise_high;
    logic                    rise_low;
  } cmp_state_t;

  cmp_state_t st;
  cmp_state_t next_st;
  logic [16:0] high_release;
  logic [16:0] low_release;

  ////////////////////////////////////////////////////////////////////////////
  // release points sit one hysteresis inside each limit, 17 bits against wrap
  always_comb begin
    high_release = {1'b0, link.result} + {11'h000, link.hyst};
    low_release  = {1'b0, link.lower_limit} + {11'h000, link.hyst};
  end

  always_comb begin
    next_st           = st;
    next_st.rise_high = 1'b0;
    next_st.rise_low  = 1'b0;
    if (link.result_valid) begin
      case (st.high_state)
        alarm_pkg::ALARM_CLEAR: begin
          if (link.result > link.upper_limit) begin
            next_st.high_state = alarm_pkg::ALARM_RAISED;
            next_st.rise_high  = 1'b1;
          end
        end
        alarm_pkg::ALARM_RAISED: begin
          if (high_release < {1'b0, link.upper_limit}) begin
            next_st.high_state = alarm_pkg::ALARM_CLEAR;
          end
        end
        default: next_st.high_state = alarm_pkg::ALARM_CLEAR;
      endcase
      case (st.low_state)
        alarm_pkg::ALARM_CLEAR: begin
          if (link.result < link.lower_limit) begin
            next_st.low_state = alarm_pkg::ALARM_RAISED;
            next_st.rise_low  = 1'b1;
          end
        end
        alarm_pkg::ALARM_RAISED: begin
          if ({1'b0, link.result} > low_release) begin
            next_st.low_state = alarm_pkg::ALARM_CLEAR;
          end
        end
        default: next_st.low_state = alarm_pkg::ALARM_CLEAR;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '{alarm_pkg::ALARM_CLEAR, alarm_pkg::ALARM_CLEAR, 1'b0, 1'b0};
    end else begin
      st <= next_st;
    end
  end

  assign link.live_high = (st.high_state == alarm_pkg::ALARM_RAISED);
  assign link.live_low  = (st.low_state == alarm_pkg::ALARM_RAISED);
  assign link.rise_high = st.rise_high;
  assign link.rise_low  = st.rise_low;

endmodule

// >>> hdl/alarm_irq.sv
// sticky event bits, write-one-to-clear, with a mask onto one level irq
// assumes clear and mask_we are one-cycle strobes from a completed bus write
`timescale 1ns/100ps
module alarm_irq #(
  parameter int N = 2
) (
  // clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // events and software access
  input  wire logic [N-1:0] event_in,
  input  wire logic [N-1:0] clear,
  input  wire logic         mask_we,
  input  wire logic [N-1:0] mask_wdata,
  // state
  output logic      [N-1:0] status,
  output logic      [N-1:0] mask,
  output logic              irq
);

  typedef struct packed {
    logic [N-1:0] status;
    logic [N-1:0] mask;
    logic         irq;
  } irq_state_t;

  irq_state_t st;
  irq_state_t next_st;

  generate
    if (N < 1 || N > 32) begin : g_bad_n
      $error("alarm_irq: N must lie in 1..32");
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // a set in the same cycle as its clear wins
  always_comb begin
    next_st = st;
    for (int i = 0; i < N; i++) begin
      next_st.status[i] = event_in[i] | (st.status[i] & ~clear[i]);
    end
    if (mask_we) begin
      next_st.mask = mask_wdata;
    end
    next_st.irq = |(next_st.status & next_st.mask);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '{'0, '0, 1'b0};
    end else begin
      st <= next_st;
    end
  end

  assign status = st.status;
  assign mask   = st.mask;
  assign irq    = st.irq;

endmodule

// >>> tb/alarm_threshold_regs_asserts.sv
// port assertions for the alarm threshold register bank
// assumes it is bound into alarm_threshold_regs
`timescale 1ns/100ps
module alarm_threshold_regs_asserts #(
  parameter int RESULT_WIDTH = 16
) (
  // clock and reset
  input wire logic                    pclk,
  input wire logic                    presetn,
  // apb slave
  input wire logic                    psel,
  input wire logic                    penable,
  input wire logic                    pwrite,
  input wire logic [7:0]              paddr,
  input wire logic [31:0]             pwdata,
  input wire logic [3:0]              pstrb,
  input wire logic [31:0]             prdata,
  input wire logic                    pready,
  input wire logic                    pslverr,
  // results and alarms
  input wire logic [RESULT_WIDTH-1:0] result,
  input wire logic                    result_valid,
  input wire logic                    alarm_high,
  input wire logic                    alarm_low,
  input wire logic                    irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic setup;
  logic mapped;
  logic rd_ack;
  assign setup  = psel && !penable;
  assign mapped = paddr inside {alarm_pkg::ADDR_STATUS, alarm_pkg::ADDR_UPPER,
                                alarm_pkg::ADDR_LOWER, alarm_pkg::ADDR_INT_STATUS,
                                alarm_pkg::ADDR_INT_MASK};
  assign rd_ack = pready && !pwrite;

  ////////////////////////////////////////////////////////////////////////////
  ready_after_setup_a: assert property (setup |=> pready)
    else $error("pready missing after setup");
  write_rdata_a: assert property (setup && pwrite |=> prdata == 32'h0)
    else $error("prdata not zero on a write");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  err_with_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  unmapped_err_a: assert property (setup && !mapped |=> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  mapped_ok_a: assert property (setup && mapped |=> !pslverr)
    else $error("mapped access refused");
  rdata_idle_a: assert property (!pready |-> prdata == 32'h0)
    else $error("prdata not zero outside access");
  upper_rsv_a: assert property (rd_ack && paddr == 8'h24 |-> prdata[23:16] == 8'h00)
    else $error("upper reserved bits not zero");
  lower_rsv_a: assert property (rd_ack && paddr == 8'h28 |-> prdata[31:16] == 16'h0)
    else $error("lower reserved bits not zero");
  summary_or_a: assert property (rd_ack && paddr == 8'h20 |-> prdata[0] == |prdata[5:4])
    else $error("summary bit not or of tripped flags");
endmodule

// >>> tb/tb_alarm_threshold_regs.sv
// self-checking bench for the alarm threshold register bank
// assumes the apb slave answers in one access cycle
`timescale 1ns/100ps
module tb_alarm_threshold_regs;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [3:0]  pstrb;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [15:0] result;
  logic        result_valid;
  logic        alarm_high;
  logic        alarm_low;
  logic        irq;
  int          num_errors;
  int          comparisons;

  alarm_threshold_regs #(.RESULT_WIDTH(16)) i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .result(result), .result_valid(result_valid),
    .alarm_high(alarm_high), .alarm_low(alarm_low), .irq(irq)
  );

  initial pclk = 1'b0;
  always #25 pclk = ~pclk;

  ////////////////////////////////////////////////////////////////////////////
  task automatic finish_test;
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      $display("Error %s expected %h seen %h", name, exp, got);
      num_errors++;
    end
  endtask

  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d,
                     input logic [3:0] s, output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    paddr   <= a;
    pwrite  <= w;
    pwdata  <= d;
    pstrb   <= s;
    @(posedge pclk);
    penable <= 1'b1;
    // only the watchdog ends a wait that never sees pready
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] r;
    logic        e;
    apb(a, 1'b1, d, s, r, e);
    chk("pslverr", 32'h0, {31'h0, e});
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic err = 1'b0);
    logic [31:0] r;
    logic        e;
    apb(a, 1'b0, 32'h0, 4'h0, r, e);
    chk("prdata", exp, r);
    chk("pslverr", {31'h0, err}, {31'h0, e});
  endtask

  // result strobe, then wait until the live flags have settled
  task automatic res(input logic [15:0] v);
    @(posedge pclk);
    result       <= v;
    result_valid <= 1'b1;
    @(posedge pclk);
    result_valid <= 1'b0;
    @(posedge pclk);
    #1;
  endtask

  initial begin
    repeat (3000) @(posedge pclk);
    num_errors++;
    finish_test();
  end

  initial begin
    num_errors   = 0;
    comparisons  = 0;
    presetn      = 1'b0;
    {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
    result       = 16'h0;
    result_valid = 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;

    rd(8'h24, 32'h0000ffff);
    rd(8'h28, 32'h00000000);
    rd(8'h20, 32'h00000000);
    rd(8'h2c, 32'h00000000);
    rd(8'h30, 32'h00000000);
    $display("test reset values done");

    wr(8'h24, 32'hfc5a1234, 4'hf);
    rd(8'h24, 32'hfc001234);
    wr(8'h24, 32'h00ff00ab, 4'h5);
    rd(8'h24, 32'hfc0012ab);
    wr(8'h24, 32'h4000ff00, 4'ha);
    rd(8'h24, 32'h4000ffab);
    wr(8'h28, 32'hffffffff, 4'hf);
    rd(8'h28, 32'h0000ffff);
    wr(8'h28, 32'h00005500, 4'h2);
    rd(8'h28, 32'h000055ff);
    rd(8'h34, 32'h0, 1'b1);
    rd(8'h26, 32'h0, 1'b1);
    $display("test register access done");

    wr(8'h24, 32'h10001000, 4'hf);
    wr(8'h28, 32'h00000100, 4'hf);
    wr(8'h30, 32'h00000001, 4'h1);
    res(16'h1001);
    chk("alarm_high", 32'h1, {31'h0, alarm_high});
    chk("irq", 32'h1, {31'h0, irq});
    rd(8'h20, 32'h00000411);
    rd(8'h20, 32'h00000400);
    res(16'h0ffd);
    chk("alarm_high", 32'h1, {31'h0, alarm_high});
    res(16'h0ffb);
    chk("alarm_high", 32'h0, {31'h0, alarm_high});
    wr(8'h2c, 32'h00000001, 4'h1);
    @(posedge pclk);
    #1;
    chk("irq", 32'h0, {31'h0, irq});
    $display("test high alarm done");

    res(16'h00ff);
    chk("alarm_low", 32'h1, {31'h0, alarm_low});
    chk("irq", 32'h0, {31'h0, irq});
    res(16'h0104);
    chk("alarm_low", 32'h1, {31'h0, alarm_low});
    res(16'h0105);
    chk("alarm_low", 32'h0, {31'h0, alarm_low});
    rd(8'h20, 32'h00000021);
    rd(8'h2c, 32'h00000002);
    wr(8'h30, 32'h00000003, 4'h1);
    @(posedge pclk);
    #1;
    chk("irq", 32'h1, {31'h0, irq});
    wr(8'h2c, 32'h00000002, 4'h1);
    @(posedge pclk);
    #1;
    chk("irq", 32'h0, {31'h0, irq});
    rd(8'h2c, 32'h00000000);
    $display("test low alarm done");
    finish_test();
  end
endmodule

bind alarm_threshold_regs alarm_threshold_regs_asserts #(.RESULT_WIDTH(RESULT_WIDTH)) i_asserts (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .result(result), .result_valid(result_valid),
  .alarm_high(alarm_high), .alarm_low(alarm_low), .irq(irq)
);
